// File: bench/opt_timers_tb.sv
// self-checking bench for the dual-role protocol timers
// assumes opt_timers built with a short tick; bench drives every port
`timescale 1ns/10ps
`include "opt_timers_defs.svh"
module opt_timers_tb;
	localparam int TC = 4;
	logic clk_sys_i = 0;
	logic reset_n_i = 0;
	logic cmd_valid_i = 0;
	logic [7:0] cmd_code_i = 8'h00;
	logic [31:0] cmd_wdata_i = 32'h00000000;
	logic [15:0] event_status_i = 16'h0000;
	logic [15:0] event_enable_i = 16'h0000;
	logic [31:0] cmd_rdata_o, rd, sv;
	logic cmd_rvalid_o, countdown_run_o, elapsed_run_o, timeout_pulse_o, timeout_irq_o;
	int n_mismatch = 0, num_checks = 0, n_to = 0, n_irq = 0, t0, b;
	opt_timers #(.TICK_CYCLES(TC)) opt_timers_inst (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
		.cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
		.event_status_i(event_status_i), .event_enable_i(event_enable_i),
		.countdown_run_o(countdown_run_o), .elapsed_run_o(elapsed_run_o),
		.timeout_pulse_o(timeout_pulse_o), .timeout_irq_o(timeout_irq_o));
	// clock, 8 ns period
	initial forever #4 clk_sys_i = ~clk_sys_i;
	// pulse tallies; a one-cycle pulse is seen at exactly one edge
	always @(posedge clk_sys_i)
	begin
		if (timeout_pulse_o === 1'b1) n_to++;
		if (timeout_irq_o === 1'b1) n_irq++;
	end
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) fail($sformatf("got %h want %h", got, exp));
	endtask
	// range check; an unknown value never lands inside
	task rng(input logic [31:0] got, input int lo, input int hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) fail($sformatf("got %0d out of range", got));
	endtask
	// all tasks start and end just after a rising edge
	task step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task wr(input logic [7:0] c, input logic [31:0] d);
		cmd_valid_i = 1;
		cmd_code_i = c;
		cmd_wdata_i = d;
		step(1);
		cmd_valid_i = 0;
		// idle cycle so the next call never re-raises valid in this step
		step(1);
	endtask
	task rdc(input logic [7:0] c, output logic [31:0] d);
		int i;
		cmd_valid_i = 1;
		cmd_code_i = c;
		step(1);
		cmd_valid_i = 0;
		for (i = 0; i < 3 && cmd_rvalid_o !== 1'b1; i++) step(1);
		if (cmd_rvalid_o !== 1'b1)
		begin
			fail("no read answer");
			test_done();
		end
		d = cmd_rdata_o;
		step(1);
	endtask
	// bounded wait for a timeout pulse, cycles waited in t0
	task wto(input int lim);
		t0 = 0;
		while (timeout_pulse_o !== 1'b1 && t0 < lim)
		begin
			step(1);
			t0++;
		end
		if (t0 == lim)
		begin
			fail("timeout never came");
			test_done();
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		step(20);
		reset_n_i = 1;
		step(1);
		rdc(`OPT_CMD_CD_RD, rd); chk(rd, `OPT_REG_RESET);
		rdc(`OPT_CMD_EL_RD, rd); chk(rd, `OPT_REG_RESET);
		rdc(8'h11, rd); chk(rd, 32'h00000000);
		$display("test reset done");
		// countdown of three ticks, interrupt enabled
		event_enable_i = 16'h0400;
		b = n_irq;
		wr(`OPT_CMD_CD_WR, 32'h80000003); step(1); chk(countdown_run_o, 1);
		wto(40); rng(t0, 2 * TC - 1, 3 * TC + 1);
		step(2); chk(countdown_run_o, 0); chk(n_irq - b, 1);
		rdc(`OPT_CMD_CD_RD, rd); chk(rd, 32'h00000003);
		// masked interrupt, single tick preset
		event_enable_i = 16'h0000;
		wr(`OPT_CMD_CD_WR, 32'h80000001); wto(20); step(2); chk(n_irq - b, 1);
		// preset zero times out at the first tick
		wr(`OPT_CMD_CD_WR, 32'h80000000); wto(20); rng(t0, 0, TC);
		step(2); chk(countdown_run_o, 0);
		// start then halt back to back: no timeout may follow
		b = n_to;
		wr(`OPT_CMD_CD_WR, 32'h80000002);
		wr(`OPT_CMD_CD_WR, 32'h00000002); step(30); chk(n_to - b, 0);
		$display("test countdown done");
		// elapsed start with reserved and read-only bits set
		wr(`OPT_CMD_EL_WR, 32'hFFFFFFFF); rdc(`OPT_CMD_EL_RD, rd); chk(rd[31:24], 8'h80);
		rng(rd[23:0], 0, 1);
		step(40);
		wr(`OPT_CMD_EL_WR, 32'h00000000); rdc(`OPT_CMD_EL_RD, sv); rng(sv, 9, 12);
		step(20); rdc(`OPT_CMD_EL_RD, rd); chk(rd, sv);
		// event without its enable must not freeze; with it, it must
		wr(`OPT_CMD_EL_WR, 32'h80000000);
		event_status_i = 16'h0008;
		event_enable_i = 16'h0010;
		step(12); chk(elapsed_run_o, 1);
		event_enable_i = 16'h0018;
		step(2); chk(elapsed_run_o, 0);
		rdc(`OPT_CMD_EL_RD, sv); rng(sv, 2, 5);
		step(16); rdc(`OPT_CMD_EL_RD, rd); chk(rd, sv);
		event_status_i = 16'h0000;
		$display("test elapsed done");
		test_done();
	end
endmodule

// File: design/opt_timers.sv
// countdown and elapsed timers for dual-role session protocols
// assumes a command-coded register port and event status/enable from the
// dual-role event logic, all on clk_sys_i
//
// Overview of operation
// - writing run one loads the preset into the countdown counter and starts it
// - writing run zero halts the countdown timer
// - countdown timeout clears its run bit without software
// - preset is 24 bits; one count is one 10 us tick
// - writing run one to elapsed timer zeroes it, then counts up per tick
// - elapsed counter stops and clears run at all-ones 24-bit value
// - writing run zero stops the elapsed counter advancing
// - enabled pending dual-role event clears elapsed run, freezing the count
// - reading elapsed field returns the counter value, units of 10 us
// - elapsed run bit is bit 31, reset zero; bits 30 to 24 reserved
// - countdown timeout raises the timer interrupt when enable bit 10 set
`timescale 1ns/10ps
`include "opt_timers_defs.svh"

module opt_timers #(
	parameter int TICK_CYCLES = `OPT_TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// command-coded register port
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [31:0] cmd_wdata_i,
	output logic [31:0] cmd_rdata_o,
	output logic cmd_rvalid_o,
	// dual-role event status and enable
	input wire logic [15:0] event_status_i,
	input wire logic [15:0] event_enable_i,
	// timer state and interrupt request
	output logic countdown_run_o,
	output logic elapsed_run_o,
	output logic timeout_pulse_o,
	output logic timeout_irq_o
);

	opt_timers_pkg::opt_state_t s_q;
	opt_timers_pkg::opt_state_t s_d;
	logic wr_cd;
	logic wr_el;
	logic event_hit;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// reads and writes are told apart by code alone
	assign wr_cd = cmd_valid_i && (cmd_code_i == `OPT_CMD_CD_WR);
	assign wr_el = cmd_valid_i && (cmd_code_i == `OPT_CMD_EL_WR);
	assign event_hit = |(event_status_i & event_enable_i);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.timeout = 1'b0;
		s_d.timeout_irq = 1'b0;
		s_d.rd_valid = 1'b0;
		// free-running divider; timers only see the one-cycle tick
		if (s_q.tick_cnt == 16'(TICK_CYCLES - 1))
		begin
			s_d.tick_cnt = 16'h0000;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
		end
		// countdown: preset N gives N ticks, preset zero times out at first tick
		if (s_q.cd_run && s_q.tick)
		begin
			if (s_q.cd_cnt <= 24'h000001)
			begin
				s_d.cd_cnt = 24'h000000;
				s_d.cd_run = 1'b0;
				s_d.timeout = 1'b1;
				s_d.timeout_irq = event_enable_i[`OPT_TMR_IE_BIT];
			end
			else
			begin
				s_d.cd_cnt = s_q.cd_cnt - 24'h000001;
			end
		end
		// software write beats the timeout's run and count update in the same cycle; the timeout pulse still fires
		if (wr_cd)
		begin
			s_d.cd_preset = cmd_wdata_i[`OPT_VAL_MSB:0];
			s_d.cd_run = cmd_wdata_i[`OPT_RUN_BIT];
			if (cmd_wdata_i[`OPT_RUN_BIT])
			begin
				s_d.cd_cnt = cmd_wdata_i[`OPT_VAL_MSB:0];
			end
			else
			begin
				// a stop that meets a tick must not take one more step
				s_d.cd_cnt = s_q.cd_cnt;
			end
		end
		// elapsed: count up, saturate at all ones
		if (s_q.el_run && s_q.tick)
		begin
			s_d.el_cnt = s_q.el_cnt + 24'h000001;
			if (s_d.el_cnt == `OPT_VAL_MAX)
			begin
				s_d.el_run = 1'b0;
			end
		end
		// an enabled event freezes the count where it stands
		if (s_q.el_run && event_hit)
		begin
			s_d.el_cnt = s_q.el_cnt;
			s_d.el_run = 1'b0;
		end
		if (wr_el)
		begin
			s_d.el_run = cmd_wdata_i[`OPT_RUN_BIT];
			if (cmd_wdata_i[`OPT_RUN_BIT])
			begin
				s_d.el_cnt = 24'h000000;
			end
			else
			begin
				// stop holds the count even when a tick falls in the same cycle
				s_d.el_cnt = s_q.el_cnt;
			end
		end
		// read answer one cycle later; unknown codes with bit 7 clear read zero
		if (cmd_valid_i && !cmd_code_i[7])
		begin
			s_d.rd_valid = 1'b1;
			case (cmd_code_i)
				`OPT_CMD_CD_RD: s_d.rd_data = {s_q.cd_run, 7'h00, s_q.cd_preset};
				`OPT_CMD_EL_RD: s_d.rd_data = {s_q.el_run, 7'h00, s_q.el_cnt};
				default: s_d.rd_data = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign cmd_rdata_o = s_q.rd_data;
	assign cmd_rvalid_o = s_q.rd_valid;
	assign countdown_run_o = s_q.cd_run;
	assign elapsed_run_o = s_q.el_run;
	assign timeout_pulse_o = s_q.timeout;
	assign timeout_irq_o = s_q.timeout_irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	tick_period_a: assert property (s_q.tick |=> !s_q.tick [*2])
		else $error("tick enable came twice within three cycles");
	cd_load_a: assert property (wr_cd && cmd_wdata_i[31] |=>
		s_q.cd_run && s_q.cd_cnt == $past(cmd_wdata_i[23:0]))
		else $error("countdown did not load the preset");
	cd_halt_a: assert property (wr_cd && !cmd_wdata_i[31] |=> !s_q.cd_run
		&& $stable(s_q.cd_cnt))
		else $error("countdown kept running after stop");
	cd_timeout_a: assert property (s_q.timeout |-> !s_q.cd_run
		|| $past(wr_cd))
		else $error("run bit still set after timeout");
	cd_irq_a: assert property (s_q.timeout_irq |-> s_q.timeout)
		else $error("timer interrupt without a timeout");
	cd_irq_en_a: assert property (s_q.cd_run && s_q.tick && s_q.cd_cnt <= 1
		&& event_enable_i[10] |=> s_q.timeout_irq)
		else $error("enabled timeout raised no interrupt");
	cd_down_a: assert property (s_q.cd_run && s_q.tick && s_q.cd_cnt > 1 && !wr_cd
		|=> s_q.cd_cnt == $past(s_q.cd_cnt) - 24'h000001)
		else $error("countdown did not step down by one");
	el_start_a: assert property (wr_el && cmd_wdata_i[31] |=>
		s_q.el_run && s_q.el_cnt == 24'h000000)
		else $error("elapsed timer did not restart from zero");
	el_sat_a: assert property (s_q.el_cnt == 24'hFFFFFF |-> !s_q.el_run
		|| $past(wr_el))
		else $error("elapsed timer running at all ones");
	el_freeze_a: assert property (s_q.el_run && event_hit && !wr_el |=>
		!s_q.el_run && s_q.el_cnt == $past(s_q.el_cnt))
		else $error("enabled event did not freeze elapsed timer");
	el_idle_a: assert property (!s_q.el_run && !wr_el |=> $stable(s_q.el_cnt))
		else $error("stopped elapsed timer moved");
	el_read_a: assert property (cmd_valid_i && cmd_code_i == 8'h6C |=> cmd_rvalid_o
		&& cmd_rdata_o[23:0] == $past(s_q.el_cnt) && cmd_rdata_o[30:24] == 7'h00)
		else $error("elapsed read returned wrong value");
	el_stop_a: assert property (wr_el && !cmd_wdata_i[31] |=> !s_q.el_run
		&& $stable(s_q.el_cnt))
		else $error("elapsed timer moved after stop");
	cd_read_a: assert property (cmd_valid_i && cmd_code_i == 8'h6A |=> cmd_rvalid_o
		&& cmd_rdata_o[23:0] == $past(s_q.cd_preset) && cmd_rdata_o[30:24] == 7'h00)
		else $error("countdown read returned wrong value");
	timeout_once_a: assert property (s_q.timeout |=> !s_q.timeout)
		else $error("timeout pulse lasted more than one cycle");

	cd_timeout_c: cover property (s_q.timeout_irq);
	el_freeze_c: cover property (s_q.el_run && event_hit);
	el_read_c: cover property (cmd_rvalid_o && cmd_rdata_o[31]);
	// software stops while each timer is running
	cd_halt_c: cover property (wr_cd && !cmd_wdata_i[31] && s_q.cd_run);
	el_stop_c: cover property (wr_el && !cmd_wdata_i[31] && s_q.el_run);

endmodule

// File: design/opt_timers_defs.svh
// command codes, field positions, reset values and timing counts for the
// dual-role protocol timers; definitions only
`ifndef OPT_TIMERS_DEFS_SVH
`define OPT_TIMERS_DEFS_SVH

// command codes on the register port
`define OPT_CMD_CD_RD 8'h6A
`define OPT_CMD_CD_WR 8'hEA
`define OPT_CMD_EL_RD 8'h6C
`define OPT_CMD_EL_WR 8'hEC

// field layout shared by both timer registers
`define OPT_RUN_BIT 31
`define OPT_VAL_MSB 23
`define OPT_VAL_W 24
`define OPT_VAL_MAX 24'hFFFFFF
`define OPT_REG_RESET 32'h00000000

// timeout enable bit of the dual-role event enable register
`define OPT_TMR_IE_BIT 10

// tick timing: 10 us tick from an 8 ns clock
`define OPT_TICK_NS 10000
`define OPT_CLK_NS 8
`define OPT_TICK_CYC ((`OPT_TICK_NS) / (`OPT_CLK_NS))

`endif

// File: design/opt_timers_pkg.sv
// types of the dual-role protocol timers
// assumes the defs header for widths
`include "opt_timers_defs.svh"

package opt_timers_pkg;

	// whole state of the timer block
	typedef struct packed {
		logic [15:0] tick_cnt;
		logic tick;
		logic cd_run;
		logic [`OPT_VAL_MSB:0] cd_preset;
		logic [`OPT_VAL_MSB:0] cd_cnt;
		logic el_run;
		logic [`OPT_VAL_MSB:0] el_cnt;
		logic [31:0] rd_data;
		logic rd_valid;
		logic timeout;
		logic timeout_irq;
	} opt_state_t;

endpackage
